// ---- core/sweep_pkg.sv ----
package sweep_pkg;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STAT_ADDR = 4'h4;

    // ------------------------------------------------------------
    // Display and source modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DISP_MAIN_ONLY      = 2'b00,
        DISP_MAIN_HIGHLIGHT = 2'b01,
        DISP_DELAYED_ONLY   = 2'b10,
        DISP_ALTERNATE      = 2'b11
    } disp_mode_t;

    // Control word, bit 0 upward: disp_mode[1:0], xy_mode, channel_alternate_mode,
    // delayed_start_direct
    typedef struct packed {
        logic delayed_start_direct;
        logic channel_alternate_mode;
        logic xy_mode;
        disp_mode_t disp_mode;
    } ctrl_t;

    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RST = 5'h10;

    // Sweep events arriving on pins
    typedef struct packed {
        logic ramp_max;
        logic dtrig;
        logic delay_cmp;
        logic main_end;
    } sweep_ev_t;

    localparam logic [3:0] EV_RST = 4'h0;

    // Status word, bit 0 upward: sweep_q, sweep_qn, sel_q, sel_qn, lockout_hold,
    // stage2_q, sweep_count[7:0]
    typedef struct packed {
        logic [7:0] sweep_count;
        logic stage2_q;
        logic lockout_hold;
        logic sel_qn;
        logic sel_q;
        logic sweep_qn;
        logic sweep_q;
    } status_t;

    localparam int STAT_W = 14;
    localparam int COUNT_W = 8;

    // Horizontal source select, exactly one bit high
    typedef struct packed {
        logic xy;
        logic delayed;
        logic main_ramp;
    } xsel_t;

    localparam logic [2:0] XSEL_RST = 3'h1;

endpackage

// ---- core/bistable_cell.sv ----
`timescale 1ns/1ps

// Edge-event bistable with level preset/clear that override the clocked path.
// Preset and clear together force both outputs high.
module bistable_cell #(
    parameter logic RST_Q = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Controls
    input wire logic preset,
    input wire logic clear,
    input wire logic tick,
    input wire logic d,
    // State
    output logic q,
    output logic q_n
);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= RST_Q;
            q_n <= ~RST_Q;
        end else if (preset && clear) begin
            q <= 1'b1;
            q_n <= 1'b1;
        end else if (clear) begin
            q <= 1'b0;
            q_n <= 1'b1;
        end else if (preset) begin
            q <= 1'b1;
            q_n <= 1'b0;
        end else if (tick) begin
            q <= d;
            q_n <= ~d;
        end
    end

endmodule

// ---- core/dual_sweep_x_source_select.sv ----
`timescale 1ns/1ps

// Summary of operation
// - Setting the delayed-sweep bistable starts the delayed ramp: run high, flyback low.
// - Delayed ramp reaching its maximum level clears the delayed-sweep bistable.
// - Delayed sweep has no hold-off or free run; only its start event starts it.
// - Delayed-sweep reset clocks a low into the lockout, holding the sweep cleared.
// - Main-sweep end presets the lockout, releasing the hold for the next start.
// - Main-only mode holds the delayed-sweep bistable cleared continuously.
// - Exactly one of main ramp, delayed ramp or X-Y input drives horizontal.
// - Main-only and highlighted modes hold the selection bistable cleared: main ramp.
// - Delayed-only mode holds the selection bistable preset: delayed ramp.
// - Alternate mode toggles selection at each main-sweep end while stage two presets.
// - With channel alternate, stage two is freed: two main then two delayed sweeps.
// - Alternate mode enables trace separation on delayed sweeps only.
// - X-Y mode selects X-Y input and forces both selection outputs high.
// - Delayed sweep starts on delay edge directly, or on first trigger after arming.
module dual_sweep_x_source_select
    import sweep_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Register port
    input wire logic [sweep_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [sweep_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [sweep_pkg::DATA_W-1:0] reg_rdata,
    // Sweep event pins
    input wire sweep_pkg::sweep_ev_t ev_pins,
    // Delayed ramp control
    output logic delayed_ramp_run,
    output logic delayed_flyback,
    // Horizontal source and trace separation
    output sweep_pkg::xsel_t xsel,
    output logic trace_sep_en
);
    import sweep_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic rise(input logic now, input logic prev);
        rise = now & ~prev;
    endfunction

    function automatic logic mode_is(input ctrl_t c, input disp_mode_t m);
        mode_is = (c.disp_mode == m);
    endfunction

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1_r;
    logic rst_sync_r;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_sync_r <= rst_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ------------------------------------------------------------
    sweep_ev_t ev_s1_r;
    sweep_ev_t ev_s2_r;
    sweep_ev_t ev_d_r;

    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            ev_s1_r <= sweep_ev_t'(EV_RST);
            ev_s2_r <= sweep_ev_t'(EV_RST);
            ev_d_r <= sweep_ev_t'(EV_RST);
        end else begin
            ev_s1_r <= ev_pins;
            ev_s2_r <= ev_s1_r;
            ev_d_r <= ev_s2_r;
        end
    end

    logic cmp_rise;
    logic dtrig_rise;
    logic main_rise;

    assign cmp_rise = rise(ev_s2_r.delay_cmp, ev_d_r.delay_cmp);
    assign dtrig_rise = rise(ev_s2_r.dtrig, ev_d_r.dtrig);
    assign main_rise = rise(ev_s2_r.main_end, ev_d_r.main_end);

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    ctrl_t ctrl_r;

    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            ctrl_r <= ctrl_t'(CTRL_RST);
        end else if (reg_wr && reg_addr == CTRL_ADDR) begin
            ctrl_r <= ctrl_t'(reg_wdata[CTRL_W-1:0]);
        end
    end

    logic m_main_only;
    logic m_highlight;
    logic m_delayed_only;
    logic m_alternate;
    logic m_xy;

    assign m_main_only = mode_is(ctrl_r, DISP_MAIN_ONLY);
    assign m_highlight = mode_is(ctrl_r, DISP_MAIN_HIGHLIGHT);
    assign m_delayed_only = mode_is(ctrl_r, DISP_DELAYED_ONLY);
    assign m_alternate = mode_is(ctrl_r, DISP_ALTERNATE);
    assign m_xy = ctrl_r.xy_mode;

    // ------------------------------------------------------------
    // Delayed-sweep bistable
    // ------------------------------------------------------------
    logic sweep_q;
    logic sweep_qn;
    logic sweep_tick;
    logic sweep_d;
    logic sweep_clear;
    logic lock_q;
    logic lock_qn;

    // Direct start clocks a high on the delay edge; gated start is armed by
    // the comparator level and clocked by the delayed trigger
    assign sweep_tick = ctrl_r.delayed_start_direct ? cmp_rise : dtrig_rise;
    assign sweep_d = ctrl_r.delayed_start_direct ? 1'b1 : ev_s2_r.delay_cmp;
    assign sweep_clear = ev_s2_r.ramp_max | lock_qn | m_main_only;

    bistable_cell #(
        .RST_Q(1'b0)
    ) u_sweep (
        .clk_sys(clk_sys),
        .rst_n(rst_sync_r),
        .preset(1'b0),
        .clear(sweep_clear),
        .tick(sweep_tick),
        .d(sweep_d),
        .q(sweep_q),
        .q_n(sweep_qn)
    );

    // ------------------------------------------------------------
    // Lockout bistable
    // ------------------------------------------------------------
    logic sweep_qn_d_r;
    logic lock_tick;

    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            sweep_qn_d_r <= 1'b1;
        end else begin
            sweep_qn_d_r <= sweep_qn;
        end
    end

    assign lock_tick = rise(sweep_qn, sweep_qn_d_r);

    // Data tied low; main-sweep end level presets it
    bistable_cell #(
        .RST_Q(1'b1)
    ) u_lockout (
        .clk_sys(clk_sys),
        .rst_n(rst_sync_r),
        .preset(ev_s2_r.main_end),
        .clear(1'b0),
        .tick(lock_tick),
        .d(1'b0),
        .q(lock_q),
        .q_n(lock_qn)
    );

    // ------------------------------------------------------------
    // Source selection: stage one and stage two
    // ------------------------------------------------------------
    logic sel_q;
    logic sel_qn;
    logic sel_preset;
    logic sel_clear;
    logic sel_d;
    logic st2_q;
    logic st2_qn;

    assign sel_preset = m_delayed_only | m_xy;
    assign sel_clear = m_main_only | m_highlight | m_xy;
    // J and K both follow stage two: toggle when high, hold when low
    assign sel_d = st2_q ? ~sel_q : sel_q;

    bistable_cell #(
        .RST_Q(1'b0)
    ) u_select (
        .clk_sys(clk_sys),
        .rst_n(rst_sync_r),
        .preset(sel_preset),
        .clear(sel_clear),
        .tick(main_rise),
        .d(sel_d),
        .q(sel_q),
        .q_n(sel_qn)
    );

    // Held preset unless channel alternate frees it to divide
    bistable_cell #(
        .RST_Q(1'b1)
    ) u_stage2 (
        .clk_sys(clk_sys),
        .rst_n(rst_sync_r),
        .preset(~ctrl_r.channel_alternate_mode),
        .clear(1'b0),
        .tick(main_rise),
        .d(st2_qn),
        .q(st2_q),
        .q_n(st2_qn)
    );

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------
    xsel_t xsel_nxt;

    always_comb begin
        xsel_nxt = '0;
        if (m_xy) begin
            xsel_nxt.xy = 1'b1;
        end else if (sel_q) begin
            xsel_nxt.delayed = 1'b1;
        end else begin
            xsel_nxt.main_ramp = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            delayed_ramp_run <= 1'b0;
            delayed_flyback <= 1'b1;
        end else begin
            delayed_ramp_run <= sweep_q;
            delayed_flyback <= sweep_qn;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            xsel <= xsel_t'(XSEL_RST);
            trace_sep_en <= 1'b0;
        end else begin
            xsel <= xsel_nxt;
            trace_sep_en <= m_alternate & ~m_xy & sel_q & ~sel_qn;
        end
    end

    // ------------------------------------------------------------
    // Delayed sweep counter and register reads
    // ------------------------------------------------------------
    logic [COUNT_W-1:0] sweep_count_r;
    logic sweep_q_d_r;
    status_t status;

    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            sweep_q_d_r <= 1'b0;
            sweep_count_r <= '0;
        end else begin
            sweep_q_d_r <= sweep_q;
            if (rise(sweep_q, sweep_q_d_r)) begin
                sweep_count_r <= sweep_count_r + 8'h01;
            end
        end
    end

    always_comb begin
        status.sweep_count = sweep_count_r;
        status.stage2_q = st2_q;
        status.lockout_hold = lock_qn;
        status.sel_qn = sel_qn;
        status.sel_q = sel_q;
        status.sweep_qn = sweep_qn;
        status.sweep_q = sweep_q;
    end

    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            reg_rdata <= '0;
        end else if (reg_rd && reg_addr == CTRL_ADDR) begin
            reg_rdata <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_r};
        end else if (reg_rd && reg_addr == STAT_ADDR) begin
            reg_rdata <= {{(DATA_W-STAT_W){1'b0}}, status};
        end else begin
            reg_rdata <= '0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sweep_start_out:
    assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
        $rose(sweep_q) |=> delayed_ramp_run && !delayed_flyback)
        else $error("delayed ramp outputs did not follow sweep set");

    a_ramp_max_clear:
    assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
        ev_s2_r.ramp_max |=> !sweep_q ##1 !delayed_ramp_run)
        else $error("ramp maximum did not clear delayed sweep");

    a_no_free_run:
    assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
        $rose(sweep_q) |-> $past(sweep_tick))
        else $error("delayed sweep started without start event");

    a_lockout_hold_set:
    assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
        lock_tick && !ev_s2_r.main_end |=> lock_qn ##0 !sweep_q)
        else $error("lockout not taken after delayed sweep reset");

    a_lockout_release:
    assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
        ev_s2_r.main_end |=> !lock_qn)
        else $error("main sweep end did not release lockout");

    a_main_only_inhibit:
    assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
        m_main_only |=> !sweep_q)
        else $error("delayed sweep ran in main-only mode");

    a_xsel_onehot:
    assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
        $onehot(xsel))
        else $error("horizontal source select not one-hot");

    a_main_forced:
    assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
        (m_main_only || m_highlight) && !m_xy ##1 (m_main_only || m_highlight) && !m_xy
        |-> !sel_q ##1 xsel.main_ramp)
        else $error("main ramp not forced in main modes");

    a_delayed_forced:
    assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
        m_delayed_only && !m_xy ##1 m_delayed_only && !m_xy |-> sel_q ##1 xsel.delayed)
        else $error("delayed ramp not forced in delayed-only mode");

    a_alt_toggle:
    assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
        m_alternate && !m_xy && !ctrl_r.channel_alternate_mode && st2_q && main_rise
        |=> sel_q != $past(sel_q))
        else $error("selection did not toggle at main sweep end");

    a_div4_hold:
    assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
        m_alternate && !m_xy && ctrl_r.channel_alternate_mode && !st2_q && main_rise
        |=> $stable(sel_q) && st2_q)
        else $error("divide-by-four sequence broken");

    a_trace_sep:
    assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
        trace_sep_en |-> xsel.delayed && !xsel.main_ramp)
        else $error("trace separation on a non-delayed sweep");

    a_xy_both_high:
    assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
        m_xy |=> sel_q && sel_qn && xsel.xy)
        else $error("X-Y mode did not force selection outputs high");

    a_gated_start:
    assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
        !ctrl_r.delayed_start_direct && dtrig_rise && !ev_s2_r.delay_cmp && !sweep_q
        |=> !sweep_q)
        else $error("gated sweep started before arming");

    a_clear_wins:
    assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
        sweep_clear && sweep_tick |=> !sweep_q)
        else $error("clock edge overrode held clear");

endmodule

// ---- tb/sweep_partner.sv ----
`timescale 1ns/1ps

// Main ramp and delayed ramp stand-in: one main sweep per go pulse,
// delayed ramp reaches its maximum RAMP_LEN + 1 cycles after it starts.
module sweep_partner
    import sweep_pkg::*;
#(
    parameter int DLY = 20,
    parameter int SWEEP_LEN = 60,
    parameter int END_LEN = 8,
    parameter int RAMP_LEN = 10
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Bench control
    input wire logic go,
    input wire logic [7:0] p1,
    input wire logic [7:0] p2,
    input wire logic [7:0] p3,
    output logic busy,
    output logic [7:0] phase,
    // Device side
    input wire logic delayed_ramp_run,
    output sweep_pkg::sweep_ev_t ev
);
    logic ramp_max_r;
    logic [7:0] run_cnt_r;
    logic [1:0] rest_cnt_r;

    function automatic logic hit(input logic [7:0] p);
        return busy && phase >= p && phase < p + 8'h02;
    endfunction

    // -----------------------------------------------------------
    // Main sweep sequence
    // -----------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
            phase <= 8'h00;
        end else if (go && !busy) begin
            busy <= 1'b1;
            phase <= 8'h00;
        end else if (busy) begin
            if (phase == 8'(SWEEP_LEN + END_LEN)) begin
                busy <= 1'b0;
            end
            phase <= phase + 8'h01;
        end
    end

    // -----------------------------------------------------------
    // Delayed ramp: max level held until flyback has lasted 3 cycles
    // -----------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ramp_max_r <= 1'b0;
            run_cnt_r <= 8'h00;
            rest_cnt_r <= 2'h0;
        end else if (delayed_ramp_run) begin
            run_cnt_r <= run_cnt_r + 8'h01;
            rest_cnt_r <= 2'h0;
            if (run_cnt_r >= 8'(RAMP_LEN)) begin
                ramp_max_r <= 1'b1;
            end
        end else begin
            run_cnt_r <= 8'h00;
            if (rest_cnt_r < 2'h2) begin
                rest_cnt_r <= rest_cnt_r + 2'h1;
            end else begin
                ramp_max_r <= 1'b0;
            end
        end
    end

    // Main end stays high between sweeps, as in flyback
    assign ev = {ramp_max_r, hit(p1) | hit(p2) | hit(p3),
                 busy && phase >= 8'(DLY) && phase < 8'(SWEEP_LEN),
                 !busy || phase >= 8'(SWEEP_LEN)};
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps

module testbench;
    import sweep_pkg::*;
    localparam int DLY = 20;
    logic clk_sys, reset_n, reg_wr, reg_rd, go, busy;
    logic delayed_ramp_run, delayed_flyback, trace_sep_en, sel, s2;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rd;
    logic [7:0] p1, p2, p3, phase, cnt;
    sweep_ev_t ev_pins;
    xsel_t xsel;
    int mismatches, n_checks;

    dual_sweep_x_source_select dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ev_pins(ev_pins), .delayed_ramp_run(delayed_ramp_run),
        .delayed_flyback(delayed_flyback), .xsel(xsel), .trace_sep_en(trace_sep_en));

    sweep_partner #(.DLY(DLY)) far (.clk_sys(clk_sys), .reset_n(reset_n), .go(go),
        .p1(p1), .p2(p2), .p3(p3), .busy(busy), .phase(phase),
        .delayed_ramp_run(delayed_ramp_run), .ev(ev_pins));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // -----------------------------------------------------------
    // Checking and closing
    // -----------------------------------------------------------
    task automatic test_done();
        if (mismatches == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_until(input logic [7:0] t, input logic idle);
        int k;
        for (k = 0; k < 200; k++) begin
            @(posedge clk_sys);
            #1;
            if (idle ? busy === 1'b0 : (busy === 1'b1 && phase === t)) break;
        end
        if (k == 200) begin
            mismatches++;
            $display("Error at %0t: wait timed out", $time);
            test_done();
        end
    endtask

    // -----------------------------------------------------------
    // Register port
    // -----------------------------------------------------------
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask

    // -----------------------------------------------------------
    // Expected values
    // -----------------------------------------------------------
    function automatic logic [31:0] exp_status(input logic [4:0] c);
        return {18'h0, cnt, s2, 1'b0, c[2] | !sel, c[2] | sel, 1'b1, 1'b0};
    endfunction

    function automatic logic [2:0] exp_xsel(input logic [4:0] c);
        if (c[2]) return 3'h4;
        if (c[1:0] == 2'b10 || (c[1:0] == 2'b11 && sel)) return 3'h2;
        return 3'h1;
    endfunction

    task automatic one_sweep(input logic [4:0] c);
        logic started;
        started = (c[1:0] != 2'b00);
        @(posedge clk_sys);
        p1 <= 8'($urandom_range(4, 14));
        p2 <= 8'(DLY + $urandom_range(10, 14));
        p3 <= 8'($urandom_range(DLY + 40, 56));
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        wait_until(8'(DLY + 7), 1'b0);
        check(32'(delayed_ramp_run), 32'(started & c[4]));
        check(32'(delayed_flyback), 32'(!(started & c[4])));
        check(32'(xsel), 32'(exp_xsel(c)));
        check(32'(trace_sep_en), 32'(c[1:0] == 2'b11 && !c[2] && sel));
        wait_until(8'h3A, 1'b0);
        check(32'(delayed_ramp_run), 32'h0);
        wait_until(8'h00, 1'b1);
        cnt = cnt + 8'(started);
        if (c[1:0] == 2'b11) sel = s2 ? !sel : sel;
        s2 = c[3] ? !s2 : 1'b1;
        check(32'(xsel), 32'(exp_xsel(c)));
        reg_read(STAT_ADDR);
        check(rd, exp_status(c));
    endtask

    task automatic run_segment(input logic [4:0] c, input int n);
        logic [31:0] junk;
        junk = $urandom;
        reg_write(CTRL_ADDR, 32'h10);
        reg_write(STAT_ADDR, junk);
        reg_write(4'h8, junk);
        reg_write(CTRL_ADDR, {junk[31:5], c});
        sel = (c[1:0] == 2'b10);
        s2 = 1'b1;
        reg_read(4'hC);
        check(rd, 32'h0);
        reg_read(CTRL_ADDR);
        check(rd, {27'h0, c});
        repeat (4) @(posedge clk_sys);
        reg_read(STAT_ADDR);
        check(rd, exp_status(c));
        repeat (n) one_sweep(c);
    endtask

    // -----------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------
    initial begin
        logic [4:0] tbl [8];
        logic [4:0] c;
        reset_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        go = 1'b0;
        p1 = 8'h00;
        p2 = 8'h00;
        p3 = 8'h00;
        mismatches = 0;
        n_checks = 0;
        sel = 1'b0;
        s2 = 1'b1;
        cnt = 8'h00;
        tbl = '{5'h11, 5'h10, 5'h01, 5'h12, 5'h13, 5'h1B, 5'h05, 5'h0B};
        void'($urandom(32'hAB9B));
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reg_read(CTRL_ADDR);
        check(rd, 32'h10);
        reg_read(STAT_ADDR);
        check(rd, 32'h2A);
        for (int i = 0; i < 14; i++) begin
            c = (i < 8) ? tbl[i] : 5'($urandom);
            if (c[1:0] != 2'b01) c[2] = 1'b0;
            run_segment(c, (i < 8) ? 6 : $urandom_range(2, 6));
        end
        test_done();
    end
endmodule
